// >>> logic/ccio_cfg.svh
`ifndef CCIO_CFG_SVH
`define CCIO_CFG_SVH

// ==================================================
// register reset values and read-as-one masks
`define CCIO_IOC_RESET     8'h88
`define CCIO_IOC_RSVD_MASK 8'h88
`define CCIO_STS_RESET     8'hf8
`define CCIO_STS_RSVD_MASK 8'hf8
`define CCIO_IEN_RESET     8'hf8
`define CCIO_IEN_RSVD_MASK 8'hf8
`define CCIO_UNMAPPED_RD   8'hff

// ==================================================
// field positions
`define CCIO_FN_B_MSB      6
`define CCIO_FN_B_LSB      4
`define CCIO_FN_A_MSB      2
`define CCIO_FN_A_LSB      0
`define CCIO_OVF_BIT       2
`define CCIO_EVB_BIT       1
`define CCIO_EVA_BIT       0

// ==================================================
// counter and general register values
`define CCIO_GR_RESET      16'hffff
`define CCIO_CNT_MAX       16'hffff
`define CCIO_CNT_MIN       16'h0000

// ==================================================
// channel numbers with special behaviour
`define CCIO_CH_TOG_SET    2
`define CCIO_CH_PHASE      2
`define CCIO_CH_PAIR_LO    3
`define CCIO_CH_PAIR_HI    4

`endif

// >>> logic/ccio_channel.sv
`timescale 1ns/1ps
`include "ccio_cfg.svh"


module ccio_channel #(
  parameter int unsigned CHANNEL = 0
) (
  // clock and reset
  input  wire logic               clk_sys_i,
  input  wire logic               resetn_i,
  input  wire logic               standby_i,
  // 8-bit register port
  input  wire ccio_pkg::ccio_req_s reg_req_i,
  output logic [7:0]              reg_rdata_o,
  output logic                    reg_rvalid_o,
  // general registers, 16-bit port
  input  wire logic [1:0]         gr_wr_i,
  input  wire logic [15:0]        gr_wdata_i,
  output logic [15:0]             general_register_a_o,
  output logic [15:0]             general_register_b_o,
  // counter and modes
  input  wire logic [15:0]        timer_count_i,
  input  wire logic               count_step_i,
  input  wire ccio_pkg::ccio_mode_s mode_i,
  // timer pins
  input  wire logic               timer_pin_a_i,
  input  wire logic               timer_pin_b_i,
  output logic                    timer_pin_a_o,
  output logic                    timer_pin_a_oe_o,
  output logic                    timer_pin_b_o,
  output logic                    timer_pin_b_oe_o,
  // interrupt requests {overflow, b, a}
  output logic [2:0]              irq_o
);

  // ==================================================
  // channel constants
  localparam bit IS_TOG_SET = (CHANNEL == `CCIO_CH_TOG_SET);
  localparam bit IS_PHASE   = (CHANNEL == `CCIO_CH_PHASE);
  localparam bit IS_PAIR    = (CHANNEL == `CCIO_CH_PAIR_LO) || (CHANNEL == `CCIO_CH_PAIR_HI);

  // ==================================================
  // decode helpers
  function automatic logic edge_hit(input logic [1:0] sel, input logic rise,
                                    input logic fall);
    edge_hit = sel[1] ? (rise || fall) : (sel[0] ? fall : rise);
  endfunction

  function automatic logic out_next(input logic [1:0] act, input logic cur,
                                    input logic tog_set);
    case (act)
      2'b00:   out_next = cur;
      2'b01:   out_next = 1'b0;
      2'b10:   out_next = 1'b1;
      2'b11:   out_next = tog_set ? 1'b1 : !cur;
      default: out_next = cur;
    endcase
  endfunction

  function automatic logic [7:0] with_rsvd(input logic [7:0] d, input logic [7:0] m);
    with_rsvd = d | m;
  endfunction

  // ==================================================
  // registers
  logic [7:0]  ioc_ff;
  logic [7:0]  ien_ff;
  logic [2:0]  flag_ff;
  logic [2:0]  arm_ff;
  logic [15:0] cnt_prev_ff;
  logic [7:0]  rdata_ff;
  logic        rvalid_ff;
  logic [2:0]  irq_ff;
  logic [15:0] gr_ff [2];
  logic [1:0]  pin_ff;
  logic [1:0]  oe_ff;

  // ==================================================
  // access decode
  logic        soft_rst;
  logic        wr_ioc;
  logic        wr_sts;
  logic        wr_ien;
  logic        rd_sts;
  logic [7:0]  rd_mux;
  logic [7:0]  sts_view;

  assign soft_rst = !resetn_i || standby_i;
  assign wr_ioc   = reg_req_i.wr && (reg_req_i.sel == ccio_pkg::CCIO_SEL_IOC);
  assign wr_sts   = reg_req_i.wr && (reg_req_i.sel == ccio_pkg::CCIO_SEL_STS);
  assign wr_ien   = reg_req_i.wr && (reg_req_i.sel == ccio_pkg::CCIO_SEL_IEN);
  assign rd_sts   = reg_req_i.rd && !reg_req_i.wr &&
                    (reg_req_i.sel == ccio_pkg::CCIO_SEL_STS);
  assign sts_view = with_rsvd({5'h00, flag_ff}, `CCIO_STS_RSVD_MASK);

  assign rd_mux = (reg_req_i.sel == ccio_pkg::CCIO_SEL_IOC) ? ioc_ff :
                  (reg_req_i.sel == ccio_pkg::CCIO_SEL_STS) ? sts_view :
                  (reg_req_i.sel == ccio_pkg::CCIO_SEL_IEN) ? ien_ff :
                  `CCIO_UNMAPPED_RD;

  // ==================================================
  // function control
  logic                 pwm_lock;
  ccio_pkg::ccio_fn_t   fn [2];
  logic [1:0]           cap_mode;
  logic [1:0]           pin_in;
  logic [1:0]           rise;
  logic [1:0]           fall;
  logic [1:0]           match;
  logic [1:0]           capture;

  // paired pwm owns the pins; both registers fall back to plain compare
  assign pwm_lock = IS_PAIR && mode_i.combination_mode_hi;
  assign fn[0]    = pwm_lock ? 3'h0 : ioc_ff[`CCIO_FN_A_MSB:`CCIO_FN_A_LSB];
  assign fn[1]    = pwm_lock ? 3'h0 : ioc_ff[`CCIO_FN_B_MSB:`CCIO_FN_B_LSB];
  assign pin_in   = {timer_pin_b_i, timer_pin_a_i};

  always_ff @(posedge clk_sys_i) begin
    if (soft_rst) begin
      ioc_ff <= `CCIO_IOC_RESET;
    end else if (wr_ioc) begin
      ioc_ff <= with_rsvd(reg_req_i.wdata, `CCIO_IOC_RSVD_MASK);
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (soft_rst) begin
      ien_ff <= `CCIO_IEN_RESET;
    end else if (wr_ien) begin
      ien_ff <= with_rsvd(reg_req_i.wdata, `CCIO_IEN_RSVD_MASK);
    end
  end

  // ==================================================
  // per register compare and capture
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_reg
      ccio_pin_sync u_sync (
        .clk_sys_i (clk_sys_i),
        .resetn_i  (resetn_i),
        .pin_i     (pin_in[gi]),
        .rise_o    (rise[gi]),
        .fall_o    (fall[gi])
      );

      assign cap_mode[gi] = fn[gi][2];
      assign match[gi]    = !cap_mode[gi] && count_step_i &&
                            (timer_count_i == gr_ff[gi]);
      assign capture[gi]  = cap_mode[gi] &&
                            edge_hit(fn[gi][1:0], rise[gi], fall[gi]);

      // a capture beats a cpu write in the same cycle
      always_ff @(posedge clk_sys_i) begin
        if (soft_rst) begin
          gr_ff[gi] <= `CCIO_GR_RESET;
        end else if (capture[gi]) begin
          gr_ff[gi] <= timer_count_i;
        end else if (gr_wr_i[gi]) begin
          gr_ff[gi] <= gr_wdata_i;
        end
      end

      always_ff @(posedge clk_sys_i) begin
        if (soft_rst) begin
          pin_ff[gi] <= 1'b0;
        end else if (match[gi] && !pwm_lock) begin
          pin_ff[gi] <= out_next(fn[gi][1:0], pin_ff[gi], IS_TOG_SET);
        end
      end

      always_ff @(posedge clk_sys_i) begin
        if (soft_rst) begin
          oe_ff[gi] <= 1'b0;
        end else begin
          oe_ff[gi] <= !cap_mode[gi] && !pwm_lock;
        end
      end
    end
  endgenerate

  // ==================================================
  // overflow and underflow
  logic under_ok;
  logic wrap_up;
  logic wrap_down;
  logic ovf_evt;

  assign under_ok  = (IS_PHASE && mode_i.phase_count_select) ||
                     (IS_PAIR && mode_i.combination_mode_hi &&
                      !mode_i.combination_mode_lo);
  assign wrap_up   = (cnt_prev_ff == `CCIO_CNT_MAX) && (timer_count_i == `CCIO_CNT_MIN);
  assign wrap_down = (cnt_prev_ff == `CCIO_CNT_MIN) && (timer_count_i == `CCIO_CNT_MAX);
  assign ovf_evt   = count_step_i && (wrap_up || (under_ok && wrap_down));

  always_ff @(posedge clk_sys_i) begin
    if (soft_rst) begin
      cnt_prev_ff <= `CCIO_CNT_MIN;
    end else if (count_step_i) begin
      cnt_prev_ff <= timer_count_i;
    end
  end

  // ==================================================
  // status flags
  logic [2:0] set_vec;
  logic [2:0] clr_vec;
  logic [2:0] nxt_flag;
  logic [2:0] nxt_arm;

  assign set_vec  = {ovf_evt, match[1] || capture[1], match[0] || capture[0]};
  // only a written zero on an armed flag clears; ones do nothing
  assign clr_vec  = {3{wr_sts}} & arm_ff & ~reg_req_i.wdata[2:0];
  assign nxt_flag = (flag_ff & ~clr_vec) | set_vec;
  // a read arms each flag seen at one; any status write disarms all
  assign nxt_arm  = wr_sts ? 3'h0 : (rd_sts ? flag_ff : arm_ff);

  always_ff @(posedge clk_sys_i) begin
    if (soft_rst) begin
      flag_ff <= 3'h0;
      arm_ff  <= 3'h0;
    end else begin
      flag_ff <= nxt_flag;
      arm_ff  <= nxt_arm;
    end
  end

  // ==================================================
  // read data and interrupts
  always_ff @(posedge clk_sys_i) begin
    if (soft_rst) begin
      rdata_ff  <= 8'h00;
      rvalid_ff <= 1'b0;
    end else begin
      rvalid_ff <= reg_req_i.rd;
      if (reg_req_i.rd) begin
        rdata_ff <= rd_mux;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (soft_rst) begin
      irq_ff <= 3'h0;
    end else begin
      irq_ff <= flag_ff & ien_ff[2:0];
    end
  end

  assign reg_rdata_o          = rdata_ff;
  assign reg_rvalid_o         = rvalid_ff;
  assign general_register_a_o = gr_ff[0];
  assign general_register_b_o = gr_ff[1];
  assign timer_pin_a_o        = pin_ff[0];
  assign timer_pin_b_o        = pin_ff[1];
  assign timer_pin_a_oe_o     = oe_ff[0];
  assign timer_pin_b_oe_o     = oe_ff[1];
  assign irq_o                = irq_ff;

  // ==================================================
  // checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);

  sequence s_arm_a;
    rd_sts && flag_ff[0];
  endsequence

  sequence s_clear_a;
    wr_sts && !reg_req_i.wdata[0] && !set_vec[0];
  endsequence

  chk_ioc_reset_val: assert property (
    standby_i |=> (ioc_ff == `CCIO_IOC_RESET) && (flag_ff == 3'h0))
    else $error("function control not at reset value after standby");

  chk_ioc_rsvd_bits: assert property (
    (wr_ioc && !standby_i) |=> (ioc_ff[7] && ioc_ff[3] &&
      ioc_ff[6:4] == $past(reg_req_i.wdata[6:4]) &&
      ioc_ff[2:0] == $past(reg_req_i.wdata[2:0])))
    else $error("function control write stored wrongly");

  chk_sts_read_ones: assert property (
    (rd_sts && !standby_i) |=> (reg_rdata_o[7:3] == 5'h1f) &&
      (reg_rdata_o[2:0] == $past(flag_ff)))
    else $error("status read shows wrong bits");

  chk_clear_seq_a: assert property (
    (s_arm_a ##1 s_clear_a) |=> !flag_ff[0])
    else $error("flag a not cleared after read then write zero");

  chk_clear_unarmed: assert property (
    (wr_sts && flag_ff[0] && !arm_ff[0] && !standby_i) |=> flag_ff[0])
    else $error("flag a cleared without prior read");

  chk_write_one_a: assert property (
    (wr_sts && reg_req_i.wdata[0] && !set_vec[0] && !standby_i)
      |=> (flag_ff[0] == $past(flag_ff[0])))
    else $error("writing one changed flag a");

  chk_set_wins_a: assert property (
    (set_vec[0] && !standby_i) |=> flag_ff[0])
    else $error("event on flag a lost");

  chk_match_flag_b: assert property (
    (!cap_mode[1] && count_step_i && timer_count_i == gr_ff[1] && !standby_i)
      |=> flag_ff[1])
    else $error("compare match b did not set flag b");

  chk_capture_b: assert property (
    (capture[1] && !standby_i) |=> (gr_ff[1] == $past(timer_count_i)) && flag_ff[1])
    else $error("capture b did not load register b");

  chk_toggle_pin_a: assert property (
    (match[0] && !pwm_lock && fn[0] == 3'h3 && !standby_i)
      |=> (pin_ff[0] == (IS_TOG_SET ? 1'b1 : !$past(pin_ff[0]))))
    else $error("toggle code gave wrong pin a level");

  chk_pin_hold_low: assert property (
    (!pin_ff[0] && !match[0]) |=> !pin_ff[0])
    else $error("pin a rose without a compare match");

  chk_pwm_ignore: assert property (
    (pwm_lock && !standby_i) |=> ($stable(pin_ff) && !timer_pin_a_oe_o && !timer_pin_b_oe_o))
    else $error("function control acted during paired pwm");

  chk_ovf_wrap_up: assert property (
    (count_step_i && wrap_up && !standby_i) |=> flag_ff[2])
    else $error("overflow wrap did not set overflow flag");

  chk_underflow_gate: assert property (
    (count_step_i && wrap_down && !under_ok && !flag_ff[2] && !standby_i)
      |=> !flag_ff[2])
    else $error("underflow flagged outside up-down modes");

  chk_irq_gating: assert property (
    !standby_i |=> (irq_o == ($past(flag_ff) & $past(ien_ff[2:0]))))
    else $error("interrupt request not gated by enables");

  chk_rise_capture: assert property (
    (fn[0] == 3'h4 && rise[0] && !standby_i) |=> flag_ff[0])
    else $error("rising edge did not capture into register a");

endmodule // ccio_channel

// >>> logic/ccio_pin_sync.sv
`timescale 1ns/1ps
`include "ccio_cfg.svh"

module ccio_pin_sync (
  // clock and reset
  input  wire logic clk_sys_i,
  input  wire logic resetn_i,
  // pin and edges
  input  wire logic pin_i,
  output logic      rise_o,
  output logic      fall_o
);

  // ==================================================
  // three-stage synchroniser
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic lvl_ff;
  logic init_ff;
  logic [1:0] warm_ff;
  logic agree;

  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
    end else begin
      s1_ff <= pin_i;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // level only moves once stages two and three agree
  assign agree = (s2_ff == s3_ff);

  // level loads only once warm-up is done and stages two and three agree, so a pin high at reset is no edge
  // limitation: an edge in the first two cycles after reset may not be captured
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      lvl_ff  <= 1'b0;
      init_ff <= 1'b0;
      warm_ff <= 2'h0;
    end else begin
      warm_ff <= {warm_ff[0], 1'b1};
      if (agree && warm_ff[1]) begin
        lvl_ff  <= s3_ff;
        init_ff <= 1'b1;
      end
    end
  end

  assign rise_o = init_ff && agree && s3_ff && !lvl_ff;
  assign fall_o = init_ff && agree && !s3_ff && lvl_ff;

endmodule // ccio_pin_sync

// >>> logic/ccio_pkg.sv
package ccio_pkg;

  // ==================================================
  // register select, one-hot
  typedef enum logic [2:0] {
    CCIO_SEL_NONE = 3'b000,
    CCIO_SEL_IOC  = 3'b001,
    CCIO_SEL_STS  = 3'b010,
    CCIO_SEL_IEN  = 3'b100
  } ccio_sel_e;

  typedef logic [2:0] ccio_fn_t;

  // ==================================================
  // 8-bit register access request
  typedef struct packed {
    logic      rd;
    logic      wr;
    ccio_sel_e sel;
    logic [7:0] wdata;
  } ccio_req_s;

  // ==================================================
  // counter modes set elsewhere in the timer
  typedef struct packed {
    logic phase_count_select;
    logic combination_mode_hi;
    logic combination_mode_lo;
  } ccio_mode_s;

endpackage

// >>> verification/ccio_channel_tb_top.sv
`timescale 1ns/1ps

module ccio_channel_tb_top;
  // ==================================================
  // clock, reset and wiring
  logic                 clk_sys_i;
  logic                 resetn_i;
  logic                 standby_i;
  ccio_pkg::ccio_req_s  req;
  ccio_pkg::ccio_mode_s mode;
  logic [7:0]           rdata;
  logic                 rvalid;
  logic [1:0]           gr_wr;
  logic [15:0]          gr_wdata, general_register_a, general_register_b, count;
  logic                 step, host_pa, host_pb, pa_o, pa_oe, pb_o, pb_oe;
  logic [2:0]           irq;
  logic [7:0]           rdata3;
  logic                 pa3, pa3_oe, pb3, pb3_oe;
  logic [2:0]           irq3;
  wire logic            pin_a_w = pa_oe ? pa_o : host_pa;
  wire logic            pin_b_w = pb_oe ? pb_o : host_pb;
  int                   failures = 0;
  int                   total_checks = 0;

  ccio_channel #(.CHANNEL(2)) i_ccio_channel (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .standby_i(standby_i),
    .reg_req_i(req), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
    .gr_wr_i(gr_wr), .gr_wdata_i(gr_wdata),
    .general_register_a_o(general_register_a), .general_register_b_o(general_register_b),
    .timer_count_i(count), .count_step_i(step), .mode_i(mode),
    .timer_pin_a_i(pin_a_w), .timer_pin_b_i(pin_b_w),
    .timer_pin_a_o(pa_o), .timer_pin_a_oe_o(pa_oe),
    .timer_pin_b_o(pb_o), .timer_pin_b_oe_o(pb_oe), .irq_o(irq));

  // paired channel, for the pwm lock and the complementary underflow
  ccio_channel #(.CHANNEL(3)) i_ccio_channel_pair (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .standby_i(standby_i),
    .reg_req_i(req), .reg_rdata_o(rdata3), .reg_rvalid_o(),
    .gr_wr_i(gr_wr), .gr_wdata_i(gr_wdata),
    .general_register_a_o(), .general_register_b_o(),
    .timer_count_i(count), .count_step_i(step), .mode_i(mode),
    .timer_pin_a_i(host_pa), .timer_pin_b_i(host_pb),
    .timer_pin_a_o(pa3), .timer_pin_a_oe_o(pa3_oe),
    .timer_pin_b_o(pb3), .timer_pin_b_oe_o(pb3_oe), .irq_o(irq3));

  ccio_host_model i_ccio_host_model (
    .clk_sys_i(clk_sys_i), .reg_req_o(req), .reg_rdata_i(rdata), .reg_rvalid_i(rvalid),
    .gr_wr_o(gr_wr), .gr_wdata_o(gr_wdata), .timer_count_o(count), .count_step_o(step),
    .mode_o(mode), .pin_a_o(host_pa), .pin_b_o(host_pb));

  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  // ==================================================
  // comparison and closing
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic read_check(input ccio_pkg::ccio_sel_e sel, input logic [7:0] exp);
    logic [7:0] d;
    logic       v;
    i_ccio_host_model.reg_read(sel, d, v);
    check({7'h00, v, d}, {8'h01, exp});
  endtask

  task automatic wait_cycles(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask

  task automatic summarize();
    $display("checks=%0d failures=%0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ==================================================
  // register rows: select, written value, value read back
  localparam int NROW = 7;
  ccio_pkg::ccio_sel_e row_sel [NROW] = '{ccio_pkg::CCIO_SEL_IOC, ccio_pkg::CCIO_SEL_IOC,
    ccio_pkg::CCIO_SEL_IOC, ccio_pkg::CCIO_SEL_IEN, ccio_pkg::CCIO_SEL_IEN,
    ccio_pkg::CCIO_SEL_STS, ccio_pkg::CCIO_SEL_NONE};
  logic [7:0] row_wr  [NROW] = '{8'h00, 8'h77, 8'h53, 8'h07, 8'h00, 8'hff, 8'h00};
  logic [7:0] row_exp [NROW] = '{8'h88, 8'hff, 8'hdb, 8'hff, 8'hf8, 8'hf8, 8'hff};
  // compare codes; the second toggle code shows channel 2 holds high
  logic [2:0] code_tab [5] = '{3'h2, 3'h0, 3'h1, 3'h3, 3'h3};
  logic       pin_tab  [5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
  // the paired channel really toggles
  logic       pin3_tab [5] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0};

  initial begin
    standby_i = 1'b0;
    resetn_i = 1'b0;
    repeat (6) @(posedge clk_sys_i);
    #1;
    resetn_i = 1'b1;
    wait_cycles(1);
    check({11'h000, irq, pa_o, pb_o}, 16'h0000);
    check({14'h0000, pa_oe, pb_oe}, 16'h0003);
    read_check(ccio_pkg::CCIO_SEL_IOC, 8'h88);
    read_check(ccio_pkg::CCIO_SEL_STS, 8'hf8);
    read_check(ccio_pkg::CCIO_SEL_IEN, 8'hf8);
    for (int i = 0; i < NROW; i++) begin
      i_ccio_host_model.reg_write(row_sel[i], row_wr[i]);
      read_check(row_sel[i], row_exp[i]);
    end
    i_ccio_host_model.gr_write(1'b0, 16'h0010);
    i_ccio_host_model.gr_write(1'b1, 16'h0020);
    i_ccio_host_model.reg_write(ccio_pkg::CCIO_SEL_IEN, 8'h01);
    for (int i = 0; i < 5; i++) begin
      i_ccio_host_model.reg_write(ccio_pkg::CCIO_SEL_IOC, {1'b0, code_tab[i], 1'b0, code_tab[i]});
      i_ccio_host_model.step(16'h0010);
      i_ccio_host_model.step(16'h0020);
      wait_cycles(2);
      check({13'h0000, pa_o, pb_o, pa_oe}, {13'h0000, pin_tab[i], pin_tab[i], 1'b1});
      check({14'h0000, pa3, pb3}, {14'h0000, pin3_tab[i], pin3_tab[i]});
      check(16'(irq), 16'h0001);
      i_ccio_host_model.reg_write(ccio_pkg::CCIO_SEL_STS, 8'hf8);
      read_check(ccio_pkg::CCIO_SEL_STS, 8'hfb);
      i_ccio_host_model.clear_flags(8'hf8);
      wait_cycles(2);
      read_check(ccio_pkg::CCIO_SEL_STS, 8'hf8);
      check(16'(irq), 16'h0000);
    end
    // pins held high first so the hand-over to input makes no edge
    i_ccio_host_model.set_pins(1'b1, 1'b1);
    i_ccio_host_model.reg_write(ccio_pkg::CCIO_SEL_IOC, 8'hdc);
    i_ccio_host_model.step(16'h5678);
    wait_cycles(4);
    check({14'h0000, pa_oe, pb_oe}, 16'h0000);
    i_ccio_host_model.set_pins(1'b0, 1'b0);
    wait_cycles(8);
    check(general_register_b, 16'h5678);
    check(general_register_a, 16'h0010);
    read_check(ccio_pkg::CCIO_SEL_STS, 8'hfa);
    i_ccio_host_model.clear_flags(8'hf8);
    i_ccio_host_model.step(16'h1234);
    i_ccio_host_model.set_pins(1'b1, 1'b1);
    wait_cycles(8);
    check(general_register_a, 16'h1234);
    check(general_register_b, 16'h5678);
    read_check(ccio_pkg::CCIO_SEL_STS, 8'hf9);
    i_ccio_host_model.clear_flags(8'hf8);
    i_ccio_host_model.reg_write(ccio_pkg::CCIO_SEL_IOC, 8'hee);
    i_ccio_host_model.step(16'h9abc);
    i_ccio_host_model.set_pins(1'b0, 1'b0);
    wait_cycles(8);
    check(general_register_a, 16'h9abc);
    check(general_register_b, 16'h9abc);
    i_ccio_host_model.clear_flags(8'hf8);
    // wrap up, then a plain down wrap that must not count
    i_ccio_host_model.reg_write(ccio_pkg::CCIO_SEL_IOC, 8'h88);
    i_ccio_host_model.step(16'hffff);
    i_ccio_host_model.step(16'h0000);
    read_check(ccio_pkg::CCIO_SEL_STS, 8'hfc);
    i_ccio_host_model.clear_flags(8'hf8);
    i_ccio_host_model.step(16'hffff);
    wait_cycles(1);
    read_check(ccio_pkg::CCIO_SEL_STS, 8'hf8);
    i_ccio_host_model.set_phase(1'b1);
    i_ccio_host_model.step(16'h0001);
    i_ccio_host_model.step(16'h0000);
    i_ccio_host_model.step(16'hffff);
    read_check(ccio_pkg::CCIO_SEL_STS, 8'hfc);
    // paired channel: pwm lock ignores function control, complementary mode underflows
    i_ccio_host_model.set_mode(3'h2);
    i_ccio_host_model.reg_write(ccio_pkg::CCIO_SEL_IOC, 8'h8b);
    i_ccio_host_model.step(16'h9abc);
    i_ccio_host_model.step(16'h0000);
    i_ccio_host_model.step(16'hffff);
    check({12'h000, pa3, pa3_oe, pb3, pb3_oe}, 16'h0000);
    i_ccio_host_model.reg_write(ccio_pkg::CCIO_SEL_IEN, 8'h06);
    read_check(ccio_pkg::CCIO_SEL_STS, 8'hff);
    check(16'(rdata3), 16'h00ff);
    check(16'({irq, irq3}), 16'h0036);
    i_ccio_host_model.clear_flags(8'hf8);
    // reset-synchronised pwm counts up only, so no underflow
    i_ccio_host_model.set_mode(3'h3);
    i_ccio_host_model.step(16'h0001);
    i_ccio_host_model.step(16'h0000);
    i_ccio_host_model.step(16'hffff);
    read_check(ccio_pkg::CCIO_SEL_STS, 8'hf8);
    check(16'(rdata3), 16'h00f8);
    i_ccio_host_model.reg_write(ccio_pkg::CCIO_SEL_IOC, 8'h53);
    standby_i = 1'b1;
    wait_cycles(1);
    standby_i = 1'b0;
    wait_cycles(1);
    check(16'(pa_o), 16'h0000);
    read_check(ccio_pkg::CCIO_SEL_IOC, 8'h88);
    read_check(ccio_pkg::CCIO_SEL_STS, 8'hf8);
    summarize();
  end

  // ==================================================
  // watchdog, far beyond the few hundred cycles of the run
  initial begin
    #100000;
    failures++;
    summarize();
  end
endmodule // ccio_channel_tb_top

// >>> verification/ccio_host_model.sv
`timescale 1ns/1ps

// ==================================================
// host cpu on the register port, plus counter and pin drivers
module ccio_host_model (
  // clock
  input  wire logic            clk_sys_i,
  // register port
  output ccio_pkg::ccio_req_s  reg_req_o,
  input  wire logic [7:0]      reg_rdata_i,
  input  wire logic            reg_rvalid_i,
  // general registers
  output logic [1:0]           gr_wr_o,
  output logic [15:0]          gr_wdata_o,
  // counter, modes and pins
  output logic [15:0]          timer_count_o,
  output logic                 count_step_o,
  output ccio_pkg::ccio_mode_s mode_o,
  output logic                 pin_a_o,
  output logic                 pin_b_o
);
  initial begin
    reg_req_o = '0;
    reg_req_o.wdata = 8'h5a;
    gr_wr_o = 2'b00;
    gr_wdata_o = 16'ha5a5;
    timer_count_o = 16'h0000;
    count_step_o = 1'b0;
    mode_o = '0;
    pin_a_o = 1'b0;
    pin_b_o = 1'b0;
  end

  // ==================================================
  // all changes land just after a rising edge
  task automatic tick();
    @(posedge clk_sys_i);
    #1;
  endtask

  task automatic reg_write(input ccio_pkg::ccio_sel_e sel, input logic [7:0] data);
    tick();
    reg_req_o.wr = 1'b1;
    reg_req_o.sel = sel;
    reg_req_o.wdata = data;
    tick();
    reg_req_o.wr = 1'b0;
    reg_req_o.sel = ccio_pkg::CCIO_SEL_NONE;
    // released data bus shows the inverse, not a stale copy
    reg_req_o.wdata = ~data;
  endtask

  task automatic reg_read(input ccio_pkg::ccio_sel_e sel, output logic [7:0] data,
                          output logic valid);
    tick();
    reg_req_o.rd = 1'b1;
    reg_req_o.sel = sel;
    tick();
    reg_req_o.rd = 1'b0;
    reg_req_o.sel = ccio_pkg::CCIO_SEL_NONE;
    valid = reg_rvalid_i;
    data = reg_rdata_i;
  endtask

  // read arms the set flags, the write of zeros follows in the very next cycle
  task automatic clear_flags(input logic [7:0] keep);
    tick();
    reg_req_o.rd = 1'b1;
    reg_req_o.sel = ccio_pkg::CCIO_SEL_STS;
    tick();
    reg_req_o.rd = 1'b0;
    reg_req_o.wr = 1'b1;
    reg_req_o.wdata = keep;
    tick();
    reg_req_o.wr = 1'b0;
    reg_req_o.sel = ccio_pkg::CCIO_SEL_NONE;
    reg_req_o.wdata = ~keep;
  endtask

  task automatic gr_write(input logic sel_b, input logic [15:0] value);
    tick();
    gr_wr_o = sel_b ? 2'b10 : 2'b01;
    gr_wdata_o = value;
    tick();
    gr_wr_o = 2'b00;
    gr_wdata_o = ~value;
  endtask

  task automatic step(input logic [15:0] cnt);
    tick();
    timer_count_o = cnt;
    count_step_o = 1'b1;
    tick();
    count_step_o = 1'b0;
  endtask

  task automatic set_pins(input logic a, input logic b);
    tick();
    pin_a_o = a;
    pin_b_o = b;
  endtask

  task automatic set_phase(input logic on);
    tick();
    mode_o.phase_count_select = on;
  endtask

  task automatic set_mode(input ccio_pkg::ccio_mode_s m);
    tick();
    mode_o = m;
  endtask
endmodule // ccio_host_model
